/* dtm_timers.sv */
// Top of the dual eight-bit timers: basic timer, event timer, registers
//
// Summary of operation
// [R1] Basic timer counts up in 8 bits, wraps ff to 00, raises time-out request.
// [R2] Basic timer time-out wakes system from green mode while run bit set.
// [R3] Basic mode bit 7 starts and stops basic timer; resets to zero.
// [R4] Basic mode bits 6..4 pick divide 256 down to 2 for codes 000..111.
// [R5] Basic count register is read/write, resets zero, software preloads 256 minus ticks.
// [R6] Software stops, masks, clears flag, sets rate, loads count, unmasks, runs.
// [R7] Event timer counts up in 8 bits, wraps, continues and raises time-out request.
// [R8] In PWM mode overflow point follows PWM cycle set by reload and toggle bits; with pin source the code keeps the full 256.
// [R9] Event mode bit 3 picks internal clock (0) or external event pin (1).
// [R10] With external source, event timer advances once per falling edge of pin.
// [R11] External source ignores prescale code; pin interrupt flag stays zero.
// [R12] Event mode bits 6..4 pick divide: 000 by 256 through 111 by 2.
// [R13] Event mode bit 7 starts and stops event timer; whole register resets zero.
// [R14] Event mode bit 0 enables PWM output, governed by toggle and reload bits.
// [R15] Without PWM, bit 1 drives toggle signal on shared pin instead of I/O.
// [R16] Without PWM, bit 2 enables auto-reload; in PWM it has no reload meaning.
// [R17] Overflow with auto-reload loads reload value; new reload waits in staging buffer.
// [R18] PWM mode forces auto-reload; reload bit then helps pick overflow boundary.
// [R19] PWM boundary: 256 none, 64 toggle, 32 reload, 16 both bits set; with pin source the code uses 256 for all.
// [R20] Overflow sets sticky request flag; interrupt only while enable set.
// [R21] Count register write replaces count at once; counting continues from it.
//
// The strobed register port was chosen for this implementation.
`include "dtm_consts.svh"

module dtm_timers
(
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset_n,
  // Register port
  input  wire dtm_pkg::dtm_byte_t i_addr,
  input  wire dtm_pkg::dtm_byte_t i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output      dtm_pkg::dtm_byte_t o_rdata,
  // Interrupt requests and wake-up
  output      logic              o_basic_timer_irq,
  output      logic              o_event_timer_irq,
  output      logic              o_green_wake,
  // External event input pin
  input  wire logic              i_event_input_pin,
  // Shared output pin
  output      logic              o_shared_output_pin,
  output      logic              o_shared_output_pin_oe
);
  import dtm_pkg::*;

  // ========================================================================
  // State
  typedef struct packed {
    dtm_byte_t bt_mode;
    dtm_byte_t bt_cnt;
    dtm_byte_t et_mode;
    dtm_byte_t et_cnt;
    dtm_byte_t rl_stage;
    dtm_byte_t rl_active;
    logic      bt_ien;
    logic      bt_flag;
    logic      et_ien;
    logic      et_flag;
    logic      pin_s1;
    logic      pin_s2;
    logic      pin_prev;
    logic      toggle;
    logic      pin_o;
    logic      pin_oe;
    dtm_byte_t rdata;
    logic      bt_irq;
    logic      et_irq;
    logic      wake;
  } dtm_top_s;

  dtm_top_s state_r;
  dtm_top_s state_nxt;

  dtm_tick_if bt_tick_if ();
  dtm_tick_if et_tick_if ();

  // ========================================================================
  // Prescalers, one per timer
  dtm_prescaler u_bt_pre
  (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .tick_if   (bt_tick_if)
  );

  dtm_prescaler u_et_pre
  (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .tick_if   (et_tick_if)
  );

  assign bt_tick_if.rate = state_r.bt_mode[`DTM_RATE_HI:`DTM_RATE_LO];
  assign et_tick_if.rate = state_r.et_mode[`DTM_RATE_HI:`DTM_RATE_LO];

  // ========================================================================
  // Decoded controls
  logic      bt_run;
  logic      et_run;
  logic      et_ext;
  logic      et_pwm;
  logic      et_aload;
  logic      et_tgl;
  logic      pin_fall;
  logic      et_tick;
  logic      bt_tick;
  logic      bt_ovf;
  logic      et_ovf;
  logic      et_reload;
  logic      wr_bt_cnt;
  logic      wr_et_cnt;
  dtm_byte_t et_mask;

  assign bt_run   = state_r.bt_mode[`DTM_BIT_RUN];
  assign et_run   = state_r.et_mode[`DTM_BIT_RUN];
  assign et_ext   = state_r.et_mode[`DTM_BIT_SRC];
  assign et_pwm   = state_r.et_mode[`DTM_BIT_PWM];
  assign et_aload = state_r.et_mode[`DTM_BIT_ALOAD];
  assign et_tgl   = state_r.et_mode[`DTM_BIT_TOGGLE];

  // Edge taken from the second synchroniser stage only
  assign pin_fall = state_r.pin_prev & ~state_r.pin_s2;

  // External edges bypass the prescaler entirely
  assign et_tick  = et_ext ? pin_fall : et_tick_if.tick;  // see [R9] see [R10] see [R11]
  assign bt_tick  = bt_run & bt_tick_if.tick;             // see [R3]

  assign wr_bt_cnt = i_wr && (i_addr == `DTM_OFS_BT_COUNT);
  assign wr_et_cnt = i_wr && (i_addr == `DTM_OFS_ET_COUNT);

  // PWM cycle length; outside PWM or with pin source the full 256 counts
  always_comb
  begin
    et_mask = `DTM_MASK_256;
    if (et_pwm && !et_ext)
    begin
      case ({et_aload, et_tgl})   // see [R8] see [R19]
        2'b01:   et_mask = `DTM_MASK_64;
        2'b10:   et_mask = `DTM_MASK_32;
        2'b11:   et_mask = `DTM_MASK_16;
        default: et_mask = `DTM_MASK_256;
      endcase
    end
  end

  // Overflow strobes; a write to the count register in the same cycle wins
  assign bt_ovf    = bt_tick && (state_r.bt_cnt == `DTM_CNT_MAX) && !wr_bt_cnt;  // see [R1]
  assign et_ovf    = et_run && et_tick && ((state_r.et_cnt & et_mask) == et_mask)
                     && !wr_et_cnt;                                            // see [R7]
  // PWM forces reload; otherwise the reload bit decides
  assign et_reload = et_pwm | et_aload;  // see [R16] see [R18]

  // ========================================================================
  // Next state
  always_comb
  begin
    state_nxt = state_r;

    // Pin synchroniser: stage one feeds stage two only
    state_nxt.pin_s1   = i_event_input_pin;
    state_nxt.pin_s2   = state_r.pin_s1;
    state_nxt.pin_prev = state_r.pin_s2;

    // Basic timer count; a tick past ff wraps to 00 and keeps going
    if (wr_bt_cnt)
      state_nxt.bt_cnt = i_wdata;                 // see [R5] see [R21]
    else if (bt_tick)
      state_nxt.bt_cnt = state_r.bt_cnt + 8'h01;  // see [R1]

    // Event timer count and double-buffered reload
    if (wr_et_cnt)
      state_nxt.et_cnt = i_wdata;                 // see [R21]
    else if (et_ovf && et_reload)
    begin
      state_nxt.et_cnt    = state_r.rl_stage;     // see [R17]
      state_nxt.rl_active = state_r.rl_stage;
    end
    else if (et_run && et_tick)
      state_nxt.et_cnt = state_r.et_cnt + 8'h01;  // see [R7]

    // Toggle output flips once per overflow, so it runs at half rate
    if (et_ovf)
      state_nxt.toggle = ~state_r.toggle;

    // Register writes
    if (i_wr)
    begin
      case (i_addr)
        `DTM_OFS_BT_MODE:  state_nxt.bt_mode  = i_wdata & `DTM_BT_MODE_MASK;  // see [R3] see [R4]
        `DTM_OFS_ET_MODE:  state_nxt.et_mode  = i_wdata;  // see [R13] see [R12]
        `DTM_OFS_RELOAD:   state_nxt.rl_stage = i_wdata;  // see [R17]
        `DTM_OFS_IRQ_CTRL:
        begin
          state_nxt.bt_ien  = i_wdata[`DTM_BIT_BT_IEN];
          state_nxt.et_ien  = i_wdata[`DTM_BIT_ET_IEN];
          // Writing zero clears a flag; writing one leaves it alone
          state_nxt.bt_flag = state_r.bt_flag & i_wdata[`DTM_BIT_BT_FLAG];
          state_nxt.et_flag = state_r.et_flag & i_wdata[`DTM_BIT_ET_FLAG];
        end
        default: ;
      endcase
    end

    // Hardware set beats a software clear in the same cycle
    if (bt_ovf)
      state_nxt.bt_flag = 1'b1;  // see [R20] see [R1]
    if (et_ovf)
      state_nxt.et_flag = 1'b1;  // see [R20] see [R7]

    // Interrupt requests gated by their enables
    state_nxt.bt_irq = state_r.bt_flag & state_r.bt_ien;  // see [R20]
    state_nxt.et_irq = state_r.et_flag & state_r.et_ien;  // see [R20]

    // Wake pulse only for a time-out while the run bit holds
    state_nxt.wake = bt_ovf & bt_run;  // see [R2]

    // Shared pin: PWM first, then toggle, otherwise released to general I/O
    if (et_pwm)
    begin
      // Square wave at the PWM cycle rate: upper half of the window is high
      state_nxt.pin_o  = (state_r.et_cnt & et_mask) > (et_mask >> 1);  // see [R14]
      state_nxt.pin_oe = 1'b1;
    end
    else if (et_tgl)
    begin
      state_nxt.pin_o  = state_r.toggle;  // see [R15]
      state_nxt.pin_oe = 1'b1;
    end
    else
    begin
      state_nxt.pin_o  = 1'b0;
      state_nxt.pin_oe = 1'b0;            // see [R15]
    end

    // Read data stand one cycle, then return to zero
    state_nxt.rdata = `DTM_RST_BYTE;
    if (i_rd)
    begin
      case (i_addr)
        `DTM_OFS_BT_MODE:  state_nxt.rdata = state_r.bt_mode;
        `DTM_OFS_BT_COUNT: state_nxt.rdata = state_r.bt_cnt;  // see [R5]
        `DTM_OFS_ET_MODE:  state_nxt.rdata = state_r.et_mode;
        `DTM_OFS_ET_COUNT: state_nxt.rdata = state_r.et_cnt;
        `DTM_OFS_IRQ_CTRL:
        begin
          // Pin flag bit is never raised by this block
          state_nxt.rdata[`DTM_BIT_BT_IEN]  = state_r.bt_ien;
          state_nxt.rdata[`DTM_BIT_BT_FLAG] = state_r.bt_flag;
          state_nxt.rdata[`DTM_BIT_ET_IEN]  = state_r.et_ien;
          state_nxt.rdata[`DTM_BIT_ET_FLAG] = state_r.et_flag;
          state_nxt.rdata[`DTM_BIT_PIN_FLAG] = 1'b0;  // see [R11]
        end
        // Reload is write only; unmapped reads give zero
        default: state_nxt.rdata = `DTM_RST_BYTE;
      endcase
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  // ========================================================================
  // Outputs, all straight from flip-flops
  assign o_rdata                = state_r.rdata;
  assign o_basic_timer_irq      = state_r.bt_irq;
  assign o_event_timer_irq      = state_r.et_irq;
  assign o_green_wake           = state_r.wake;
  assign o_shared_output_pin    = state_r.pin_o;
  assign o_shared_output_pin_oe = state_r.pin_oe;

  // ========================================================================
  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  // Helper copies so that sampled-value functions see plain signals
  dtm_byte_t bt_cnt_q;
  dtm_byte_t et_cnt_q;
  dtm_byte_t rl_stage_q;
  logic      bt_flag_q;
  logic      bt_ien_q;
  logic      toggle_q;
  assign bt_cnt_q   = state_r.bt_cnt;
  assign et_cnt_q   = state_r.et_cnt;
  assign rl_stage_q = state_r.rl_stage;
  assign bt_flag_q  = state_r.bt_flag;
  assign bt_ien_q   = state_r.bt_ien;
  assign toggle_q   = state_r.toggle;

  sequence s_bt_wrap;
    bt_tick && (bt_cnt_q == 8'hff) && !wr_bt_cnt;
  endsequence

  sequence s_tgl_ovf;
    !et_pwm && et_tgl && et_ovf;
  endsequence

  a_bt_wrap_flag: assert property (s_bt_wrap |=> (bt_cnt_q == 8'h00) && bt_flag_q)  // see [R1]
    else $error("basic timer wrap did not clear count and set flag");

  a_green_wake_run: assert property (s_bt_wrap and bt_run |=> o_green_wake)  // see [R2]
    else $error("wake pulse missing after basic timer time-out");

  a_bt_stop_hold: assert property (!bt_run && !wr_bt_cnt |=> $stable(bt_cnt_q))  // see [R3]
    else $error("stopped basic timer changed count");

  a_count_write: assert property (wr_bt_cnt |=> bt_cnt_q == $past(i_wdata))  // see [R21]
    else $error("count write did not replace count");

  a_ext_edge_step: assert property (et_run && et_ext && pin_fall && !et_ovf && !wr_et_cnt
                                    |=> et_cnt_q == $past(et_cnt_q) + 8'h01)  // see [R10]
    else $error("event timer did not step on pin falling edge");

  a_ext_no_tick: assert property (et_run && et_ext && !pin_fall && !wr_et_cnt
                                  |=> $stable(et_cnt_q))  // see [R11]
    else $error("event timer moved without pin edge");

  a_pin_flag_zero: assert property (i_rd && i_addr == 8'hc8 |=> !o_rdata[4])  // see [R11]
    else $error("pin interrupt flag read as set");

  a_irq_gate: assert property (##1 o_basic_timer_irq == $past(bt_flag_q && bt_ien_q))  // see [R20]
    else $error("basic interrupt not gated by its enable");

  a_pwm_reload_16: assert property (et_pwm && !et_ext && et_aload && et_tgl && et_run
                                    && et_tick && (et_cnt_q[3:0] == 4'hf) && !wr_et_cnt
                                    |=> et_cnt_q == $past(rl_stage_q))  // see [R19]
    else $error("PWM 16-count boundary did not reload");

  a_toggle_pin: assert property (s_tgl_ovf |=> ##1 o_shared_output_pin == toggle_q
                                 && o_shared_output_pin_oe)  // see [R15]
    else $error("toggle signal not on shared pin");

endmodule

/* dtm_consts.svh */
// Offsets, field positions and reset values of the dual eight-bit timers
`ifndef DTM_CONSTS_SVH
`define DTM_CONSTS_SVH

// ==========================================================================
// Register offsets
`define DTM_OFS_BT_MODE   8'hd8
`define DTM_OFS_BT_COUNT  8'hd9
`define DTM_OFS_ET_MODE   8'hda
`define DTM_OFS_ET_COUNT  8'hdb
`define DTM_OFS_RELOAD    8'hcd
`define DTM_OFS_IRQ_CTRL  8'hc8

// ==========================================================================
// Mode register fields (shared layout of both timers)
`define DTM_BIT_RUN       7
`define DTM_RATE_HI       6
`define DTM_RATE_LO       4
`define DTM_BIT_SRC       3
`define DTM_BIT_ALOAD     2
`define DTM_BIT_TOGGLE    1
`define DTM_BIT_PWM       0
`define DTM_BT_MODE_MASK  8'hf1

// ==========================================================================
// Interrupt control register fields
`define DTM_BIT_BT_IEN    0
`define DTM_BIT_BT_FLAG   1
`define DTM_BIT_ET_IEN    2
`define DTM_BIT_ET_FLAG   3
`define DTM_BIT_PIN_FLAG  4

// ==========================================================================
// Reset values and counting limits
`define DTM_RST_BYTE      8'h00
`define DTM_CNT_MAX       8'hff
`define DTM_MASK_256      8'hff
`define DTM_MASK_64       8'h3f
`define DTM_MASK_32       8'h1f
`define DTM_MASK_16       8'h0f

`endif

/* dtm_pkg.sv */
// Types shared by the dual eight-bit timer modules
package dtm_pkg;

  typedef logic [7:0] dtm_byte_t;
  typedef logic [2:0] dtm_rate_t;

  // Prescaler state
  typedef struct packed {
    dtm_byte_t cnt;
    logic      tick;
  } dtm_pre_s;

endpackage

/* dtm_tick_if.sv */
// Carrier between a timer and its prescaler: rate code out, tick back
interface dtm_tick_if;
  dtm_pkg::dtm_rate_t rate;
  logic               tick;

  modport ctl (output rate, input tick);
  modport pre (input rate, output tick);
endinterface

/* dtm_prescaler.sv */
// Prescaler giving one tick every 256, 128, ... 2 clocks by rate code
module dtm_prescaler
(
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  // Rate in, tick out
  dtm_tick_if.pre   tick_if
);
  import dtm_pkg::*;

  dtm_pre_s  state_r;
  dtm_pre_s  state_nxt;
  logic [7:0] hit;

  // ========================================================================
  // Per-code terminal count: code g divides by 2^(8-g)
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : gen_hit
      assign hit[g] = &state_r.cnt[7-g:0];
    end
  endgenerate

  // Free running counter; a tick lasts one clock
  always_comb
  begin
    state_nxt      = state_r;
    state_nxt.cnt  = state_r.cnt + 8'h01;
    state_nxt.tick = hit[tick_if.rate];  // see [R4] see [R12]
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign tick_if.tick = state_r.tick;

endmodule

/* dtm_event_pin_model.sv */
// Behavioural model of the external event source feeding the event pin
module dtm_event_pin_model
(
  // Clock
  input  wire logic i_clk_sys,
  // Event pin
  output      logic o_event_input_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Pin idles high so that only commanded pulses form falling edges
  initial o_event_input_pin = 1'b1;

  // Each low phase lasts four clocks and each high phase at least four, longer than the pin synchroniser
  task automatic edges(input int n);
    repeat (n)
    begin
      @(posedge i_clk_sys);
      o_event_input_pin <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      o_event_input_pin <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
    end
  endtask
endmodule

/* tb_dual_eight_bit_timers.sv */
// Self-checking testbench of the dual eight-bit timers
module tb_dual_eight_bit_timers;
  timeunit 1ns;
  timeprecision 1ns;
  import dtm_pkg::*;

  typedef struct packed {dtm_byte_t v; dtm_byte_t m;} dtm_exp_s;

  // ==========================================================================
  // Signals
  logic               i_clk_sys;
  logic               i_reset_n;
  dtm_byte_t          i_addr;
  dtm_byte_t          i_wdata;
  logic               i_wr;
  logic               i_rd;
  dtm_byte_t          o_rdata;
  logic               o_basic_timer_irq;
  logic               o_event_timer_irq;
  logic               o_green_wake;
  logic               i_event_input_pin;
  logic               o_shared_output_pin;
  logic               o_shared_output_pin_oe;
  dtm_exp_s           exp_q[$];
  dtm_exp_s           e;
  logic               rd_pend;
  int                 fail_count;
  int                 checks;
  int                 wake_cnt;
  int                 n;
  int                 dv;
  dtm_byte_t          r;
  dtm_byte_t          mk;
  // Places that read zero after reset, reload and one unmapped place included
  dtm_byte_t          rst_ofs [7] = '{8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hc8, 8'hcd, 8'h00};

  dtm_timers dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_basic_timer_irq(o_basic_timer_irq), .o_event_timer_irq(o_event_timer_irq),
    .o_green_wake(o_green_wake), .i_event_input_pin(i_event_input_pin),
    .o_shared_output_pin(o_shared_output_pin),
    .o_shared_output_pin_oe(o_shared_output_pin_oe));

  dtm_event_pin_model ptnr (.i_clk_sys(i_clk_sys), .o_event_input_pin(i_event_input_pin));

  // ==========================================================================
  // Clock, 40 ns period
  initial
  begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  // ==========================================================================
  // Comparison and closing
  task check(input dtm_byte_t seen, input dtm_byte_t expd);
    checks++;
    if (seen !== expd)
    begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task tally_and_finish();
    $display("counts: checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // Register port master; one idle cycle between strobes keeps each driver single
  task wr(input dtm_byte_t a, input dtm_byte_t d);
    @(posedge i_clk_sys);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
  endtask

  // Expected value and care mask are queued before the strobe goes out
  task rd(input dtm_byte_t a, input dtm_byte_t v, input dtm_byte_t m);
    @(posedge i_clk_sys);
    exp_q.push_back('{v, m});
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk_sys);
    i_rd   <= 1'b0;
  endtask

  // Bounded wait on the basic timer request
  task wait_bt_irq();
    for (n = 0; n < 200 && o_basic_timer_irq !== 1'b1; n++)
      @(posedge i_clk_sys);
    if (n == 200)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  // ==========================================================================
  // Monitor: read data stand only in the cycle after the read edge
  always @(posedge i_clk_sys)
  begin
    rd_pend <= i_rd;
    if (o_green_wake === 1'b1)
      wake_cnt++;
  end

  always @(negedge i_clk_sys)
    if (rd_pend === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(o_rdata, 8'hxx);
      else
      begin
        e = exp_q.pop_front();
        check(o_rdata & e.m, e.v & e.m);
      end
    end

  // ==========================================================================
  // Main sequence
  initial
  begin
    {i_addr, i_wdata, i_wr, i_rd} = '0;
    {fail_count, checks} = '0;
    i_reset_n = 1'b0;
    void'($urandom(32'hfd5e7212));
    repeat (10) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;

    // Reset values, write-only reload and unmapped places read zero
    foreach (rst_ofs[i])
      rd(rst_ofs[i], 8'h00, 8'hff);
    wr(8'h00, 8'h5a);
    rd(8'h00, 8'h00, 8'hff);
    wr(8'hd8, 8'hff);
    rd(8'hd8, 8'hf1, 8'hff);
    wr(8'hd8, 8'h00);
    r = 8'($urandom());
    wr(8'hd9, r);
    rd(8'hd9, r, 8'hff);
    r = 8'($urandom()) & 8'h7f;
    wr(8'hda, r);
    rd(8'hda, r, 8'hff);
    $display("test registers done");

    // Basic overflow: ff wraps to 00, flag, request and one wake pulse
    // Set-up order: stop, mask and clear, rate, count, unmask, run
    wr(8'hd8, 8'h00);
    wr(8'hc8, 8'h00);
    wr(8'hd8, 8'h70);
    wr(8'hd9, 8'hfd);
    wr(8'hc8, 8'h01);
    wr(8'hd8, 8'hf0);
    wait_bt_irq();
    check(8'(wake_cnt), 8'h01);
    wr(8'hd8, 8'h70);
    rd(8'hc8, 8'h02, 8'h02);
    wr(8'hc8, 8'h01);
    rd(8'hc8, 8'h00, 8'h02);
    repeat (3) @(posedge i_clk_sys);
    check(8'(o_basic_timer_irq), 8'h00);
    $display("test basic overflow done");

    // Every prescale code on both timers: four or five ticks in the window
    wr(8'hc8, 8'h00);
    for (int t = 0; t < 2; t++)
      for (int c = 0; c < 8; c++)
      begin
        dv = 256 >> c;
        wr(8'hd8 + 8'(2 * t), 8'(c << 4));
        wr(8'hd9 + 8'(2 * t), 8'h00);
        wr(8'hd8 + 8'(2 * t), 8'h80 | 8'(c << 4));
        repeat (4 * dv + dv / 2 - 2) @(posedge i_clk_sys);
        wr(8'hd8 + 8'(2 * t), 8'(c << 4));
        rd(8'hd9 + 8'(2 * t), 8'h04, 8'hfe);
      end
    $display("test prescale done");

    // External edges with reload and toggle output; fast rate code must not count
    wr(8'hc8, 8'h04);
    wr(8'hcd, 8'hf0);
    wr(8'hdb, 8'hfe);
    wr(8'hda, 8'hfe);
    ptnr.edges(2);
    repeat (6) @(posedge i_clk_sys);
    rd(8'hdb, 8'hf0, 8'hff);
    rd(8'hc8, 8'h08, 8'h18);
    check(8'(o_event_timer_irq), 8'h01);
    check({6'h0, o_shared_output_pin_oe, o_shared_output_pin}, 8'h03);
    ptnr.edges(5);
    repeat (6) @(posedge i_clk_sys);
    rd(8'hdb, 8'hf5, 8'hff);
    wr(8'hda, 8'hf8);
    repeat (2) @(posedge i_clk_sys);
    check(8'(o_shared_output_pin_oe), 8'h00);
    wr(8'hda, 8'h00);
    $display("test event counter done");

    // PWM boundary per toggle and reload bits, with reload forced on
    for (int b = 0; b < 4; b++)
    begin
      mk = (b == 0) ? 8'hff : (b == 1) ? 8'h3f : (b == 2) ? 8'h1f : 8'h0f;
      wr(8'hc8, 8'h00);
      wr(8'hcd, 8'h00);
      wr(8'hda, 8'h71 | 8'(b << 1));
      wr(8'hdb, mk - 8'h01);
      wr(8'hda, 8'hf1 | 8'(b << 1));
      repeat (12) @(posedge i_clk_sys);
      check(8'(o_shared_output_pin_oe), 8'h01);
      wr(8'hda, 8'h71 | 8'(b << 1));
      rd(8'hc8, 8'h08, 8'h08);
      // Reload to zero at the boundary leaves a small count; a plain count past the 64, 32 or 16 boundary would not
      rd(8'hdb, 8'h00, 8'hf8);
    end
    wr(8'hda, 8'h00);
    $display("test pwm boundary done");

    repeat (4) @(posedge i_clk_sys);
    tally_and_finish();
  end
endmodule
